// ==== inc/rld_pkg.sv ====
// package for the reference ladder converter control block
// assumes an apb slave wrapper in rtl/ that reads these offsets and layouts
package rld_pkg;

  // register byte offsets (one aligned 32-bit word each)
  localparam logic [11:0] CTRL_OFFSET  = 12'h000;
  localparam logic [11:0] LEVEL_OFFSET = 12'h004;

  // control register field positions, level code width and step count
  localparam int CTRL_ON_BIT    = 7;
  localparam int CTRL_LPS_BIT   = 6;
  localparam int CTRL_OE_BIT    = 5;
  localparam int CTRL_PSS_LO    = 2;
  localparam int CTRL_NSS_BIT   = 0;
  localparam int LEVEL_CODE_W   = 5;
  localparam int LEVEL_STEPS    = 32;

  // writable bit masks; unimplemented bits are zero here
  localparam logic [7:0] CTRL_WMASK  = 8'hed;
  localparam logic [7:0] LEVEL_WMASK = 8'h1f;

  // reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'h00;

  // upper reference source codes
  typedef enum logic [1:0] {
    RLD_UP_SUPPLY   = 2'h0,
    RLD_UP_EXT_PIN  = 2'h1,
    RLD_UP_FIXED    = 2'h2,
    RLD_UP_RESERVED = 2'h3
  } rld_upper_src_t;

  // analog switch controls for the ladder and output pin
  typedef struct packed {
    logic                    ladder_on;       // ladder powered and tapped
    logic                    upper_connect;   // upper reference tied to ladder top
    logic                    lower_connect;   // lower reference tied to ladder bottom
    logic [1:0]              upper_ref_select;
    logic                    lower_ref_select;
    logic [LEVEL_CODE_W-1:0] level_code;
    logic                    short_to_upper;  // output shorted to upper reference
    logic                    short_to_lower;  // output shorted to lower reference
    logic                    pin_route;       // level routed to output pin
  } rld_analog_t;

  // pin override controls
  typedef struct packed {
    logic digital_drive_off;   // digital output driver overridden
    logic input_detect_off;    // digital input threshold detector overridden
  } rld_pin_ovr_t;

  // module state apart from the pin sampler flops
  typedef struct packed {
    logic [7:0]   ctrl;
    logic [7:0]   level;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    rld_analog_t  ana;
    rld_pin_ovr_t ovr;
    logic         pin_read;
  } rld_state_t;

endpackage : rld_pkg

// ==== rtl/rld_ctrl.sv ====
// control logic for a 32-level resistor-ladder reference converter, apb slave
// assumes a 125 MHz pclk, async active-low presetn, and that retention
// across sleep is kept by holding pclk domain state (no reset on wake)
//
// Functional notes
// [RQ1] five-bit level code selects one of 32 ladder taps
// [RQ2] enabled output equals lower plus span times code over 32
// [RQ3] disabled, low-power set, code all ones: output shorted to upper reference
// [RQ4] disabled, low-power clear, code all zeros: output shorted to lower reference
// [RQ5] low-power bit set cuts lower reference; clear cuts upper reference
// [RQ6] upper select: 00 supply, 01 external pin, 10 fixed buffer, 11 reserved
// [RQ7] lower select: 0 ground, 1 external negative reference pin
// [RQ8] pin drive enable routes the level to the output pin
// [RQ9] routed pin overrides digital output driver and input threshold detector
// [RQ10] digital read of a routed pin returns zero
// [RQ11] software clamps to upper by disabling, low-power set, code all ones
// [RQ12] control register contents survive wake from sleep
// [RQ13] software should disable the reference before sleep
// [RQ14] any reset disables, unroutes pin and clears code; all bits zero
// [RQ15] unimplemented bits ignore writes and read as zero
// [RQ16] enable bit turns the converter on and off
// [RQ17] writes act on the completing edge; switches follow stored values

module rld_ctrl (
  // apb clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  // analog switch controls
  output rld_pkg::rld_analog_t            analog_ctl,
  // output pin overrides
  output rld_pkg::rld_pin_ovr_t           pin_override,
  // digital read path of the level output pin
  input  wire logic                       level_output_pin_in,
  output logic                            level_output_pin_read
);

  rld_pkg::rld_state_t st_r;
  rld_pkg::rld_state_t st_nxt;

  // pin sampler: three flops, a change counts once stages two and three agree
  logic [2:0] pin_sync_r;
  logic       pin_clean_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r  <= 3'h0;
      pin_clean_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], level_output_pin_in};
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_clean_r <= pin_sync_r[2];
      end
    end
  end

  // apb decode helpers
  logic       acc_phase;
  logic       hit_ctrl;
  logic       hit_level;
  logic [7:0] ctrl_v;
  logic [7:0] level_v;
  logic       on_v;
  logic       lps_v;
  logic       full_code;
  logic       zero_code;

  assign acc_phase = psel && penable;
  assign hit_ctrl  = paddr == rld_pkg::CTRL_OFFSET;
  assign hit_level = paddr == rld_pkg::LEVEL_OFFSET;

  // next state: register file, bus answer and analog decode
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    ctrl_v         = st_r.ctrl;
    level_v        = st_r.level;

    // setup phase: answer in the following access cycle, zero wait
    if (psel && !penable) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h0000_0000;
      if (!(hit_ctrl || hit_level)) begin
        st_nxt.pslverr = 1'b1;    // unmapped address
      end else if (!pwrite) begin
        // unimplemented bits always zero in storage, so they read as zero
        st_nxt.prdata = {24'h00_0000, hit_ctrl ? st_r.ctrl : st_r.level}; // RQ15
      end
    end

    // write lands on the edge that completes the access
    if (acc_phase && st_r.pready && pwrite && pstrb[0]) begin
      if (hit_ctrl) begin
        ctrl_v = pwdata[7:0] & rld_pkg::CTRL_WMASK;     // RQ15
      end
      if (hit_level) begin
        level_v = pwdata[7:0] & rld_pkg::LEVEL_WMASK;   // RQ15
      end
    end
    st_nxt.ctrl  = ctrl_v;    // RQ17
    st_nxt.level = level_v;   // RQ1

    // analog switches decoded from the new stored values, so they move with them
    on_v      = ctrl_v[rld_pkg::CTRL_ON_BIT];
    lps_v     = ctrl_v[rld_pkg::CTRL_LPS_BIT];
    full_code = level_v[rld_pkg::LEVEL_CODE_W-1:0] == 5'h1f;
    zero_code = level_v[rld_pkg::LEVEL_CODE_W-1:0] == 5'h00;

    st_nxt.ana.ladder_on        = on_v;                                       // RQ16
    st_nxt.ana.level_code       = level_v[rld_pkg::LEVEL_CODE_W-1:0];        // RQ2
    st_nxt.ana.upper_ref_select = ctrl_v[rld_pkg::CTRL_PSS_LO +: 2];         // RQ6
    st_nxt.ana.lower_ref_select = ctrl_v[rld_pkg::CTRL_NSS_BIT];             // RQ7
    // enabled: both ends tied for the ratio; disabled: one end cut for low power
    st_nxt.ana.upper_connect    = on_v || lps_v;                              // RQ5
    st_nxt.ana.lower_connect    = on_v || !lps_v;                             // RQ5
    st_nxt.ana.short_to_upper   = !on_v && lps_v && full_code;                // RQ3
    st_nxt.ana.short_to_lower   = !on_v && !lps_v && zero_code;               // RQ4
    st_nxt.ana.pin_route        = ctrl_v[rld_pkg::CTRL_OE_BIT];              // RQ8

    // routed pin: digital buffers overridden and reads forced low
    st_nxt.ovr.digital_drive_off = ctrl_v[rld_pkg::CTRL_OE_BIT];             // RQ9
    st_nxt.ovr.input_detect_off  = ctrl_v[rld_pkg::CTRL_OE_BIT];             // RQ9
    st_nxt.pin_read = ctrl_v[rld_pkg::CTRL_OE_BIT] ? 1'b0 : pin_clean_r;     // RQ10
  end

  // state register; only presetn clears it, so sleep and wake keep contents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= '0;                         // RQ14
      st_r.ctrl  <= rld_pkg::CTRL_RESET;        // RQ14
      st_r.level <= rld_pkg::LEVEL_RESET;       // RQ14
    end else begin
      st_r <= st_nxt;                           // RQ12
    end
  end

  // outputs straight from flops
  assign pready                = st_r.pready;
  assign prdata                = st_r.prdata;
  assign pslverr               = st_r.pslverr;
  assign analog_ctl            = st_r.ana;
  assign pin_override          = st_r.ovr;
  assign level_output_pin_read = st_r.pin_read;

endmodule : rld_ctrl

// ==== testbench/rld_ctrl_props.sv ====
// assertions on the ladder converter control ports
// assumes a bind onto rld_ctrl from the bench top
module rld_ctrl_chk (
  // clock, reset and apb
  input wire logic                  pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata, prdata,
  input wire logic [3:0]            pstrb,
  input wire logic                  pready, pslverr,
  // switch controls and pin
  input wire rld_pkg::rld_analog_t  analog_ctl,
  input wire rld_pkg::rld_pin_ovr_t pin_override,
  input wire logic                  level_output_pin_in, level_output_pin_read
);
  timeunit 1ns;
  timeprecision 1ps;
  wire rld_pkg::rld_analog_t a = analog_ctl;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answers and stored writes
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_code_write: assert property (
    pready && penable && pwrite && pstrb[0] && paddr == rld_pkg::LEVEL_OFFSET
    |=> a.level_code == $past(pwdata[4:0])) else $error("code not stored");
  // pin takeover, read only zero while routed
  a_pin_ovr: assert property (pin_override == {2{a.pin_route}})
    else $error("override differs from route");
  a_read_zero: assert property (a.pin_route |-> !level_output_pin_read)
    else $error("routed pin read not zero");
  // first edge after release still shows reset values, hence the past guard
  a_one_side: assert property (
    $past(presetn) && !a.ladder_on |-> a.upper_connect != a.lower_connect)
    else $error("low power side wrong");
  a_clamp_up: assert property (
    a.short_to_upper == (!a.ladder_on && a.upper_connect && a.level_code == 5'h1f))
    else $error("upper clamp wrong");
  a_clamp_low: assert property (
    a.short_to_lower == (!a.ladder_on && a.lower_connect && a.level_code == 5'h00))
    else $error("lower clamp wrong");
  c_err: cover property (pslverr);
  c_up: cover property (a.short_to_upper);
  c_route: cover property (a.ladder_on && a.pin_route);
endmodule : rld_ctrl_chk

// ==== testbench/tb_top.sv ====
// bench for rld_ctrl: apb tasks, field compares
// assumes rld_pkg and the checker are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                  pwrite = 1'b0, pin = 1'b0, pready, pslverr, pread, er;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0, prdata, rd;
  logic [3:0]            pstrb = 4'h0;
  rld_pkg::rld_analog_t  ac;
  rld_pkg::rld_pin_ovr_t po;
  int                    fails = 0, num_checks = 0;
  localparam logic [11:0] CT = rld_pkg::CTRL_OFFSET, LV = rld_pkg::LEVEL_OFFSET;
  rld_ctrl u_rld_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .analog_ctl(ac), .pin_override(po),
    .level_output_pin_in(pin), .level_output_pin_read(pread));
  initial forever #4 pclk = ~pclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one apb transfer; waits for pready with a bound, no fixed latency
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    // let the completing edge settle before any compare looks at the outputs
    @(negedge pclk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'h1);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(rd, e);
  endtask : rdc
  task give_verdict;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    #50000;
    fails++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CT, 32'h0);
    rdc(LV, 32'h0);
    chk(32'({ac.short_to_lower, ac.lower_connect, ac.upper_connect, ac.ladder_on, po}), 32'h30);
    wr(CT, 32'hff);
    wr(LV, 32'hff);
    rdc(CT, 32'hed);
    rdc(LV, 32'h1f);
    pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'({ac.upper_connect, ac.lower_connect, ac.ladder_on, po, pread}), 32'h3e);
    xfer(1'b1, CT, 32'h0, 4'h0); // strobe off, ignored
    xfer(1'b1, 12'h00c, 32'h0, 4'h1); // unmapped, refused
    chk(32'(er), 32'h1);
    rdc(CT, 32'hed);
    // off, low power set, code all ones: every upper source clamps
    for (int i = 0; i < 4; i++) begin
      wr(CT, 32'(8'h40 | (i << 2) | (i & 1)));
      chk(32'({ac.upper_ref_select, ac.lower_ref_select, ac.short_to_upper}), 32'(i << 2 | (i & 1) << 1 | 1));
    end
    wr(CT, 32'h0);
    for (int i = 0; i < 32; i++) begin
      wr(LV, 32'(i));
      chk(32'({ac.level_code, ac.short_to_lower}), 32'(i << 1 | (i == 0)));
    end
    chk(32'({pread, ac.pin_route}), 32'h2);
    wr(CT, 32'ha1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CT, 32'h0);
    rdc(LV, 32'h0);
    give_verdict();
  end
endmodule : tb_top
bind rld_ctrl rld_ctrl_chk u_rld_ctrl_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .analog_ctl(analog_ctl),
  .pin_override(pin_override), .level_output_pin_in(level_output_pin_in),
  .level_output_pin_read(level_output_pin_read));
